// File: logic/bidir_clocked_fifo_mailbox_regs.svh
// depth, widths, reset values and offset codes of the two-way queue block
`ifndef BIDIR_CLOCKED_FIFO_MAILBOX_REGS_SVH
`define BIDIR_CLOCKED_FIFO_MAILBOX_REGS_SVH

`define WORD_W          36
`define QUEUE_DEPTH     64
`define LEVEL_W         7
`define QUEUE_FULL_LVL  7'h40
`define PIN_CTRL_W      4
`define FLAG_W          4
// flag vector positions: full, almost full, empty, almost empty
`define FLAG_FULL       3
`define FLAG_AFULL      2
`define FLAG_EMPTY      1
`define FLAG_AEMPTY     0
// after reset only almost full and the two mail flags are high
`define FLAG_RST        4'h4
`define MAIL_FLAG_RST   1'b1
// almost offsets chosen by {hi, lo} select pins at reset release
`define OFFSET_HH       7'h10
`define OFFSET_HL       7'h0c
`define OFFSET_LH       7'h08
`define OFFSET_LL       7'h04
`define OFFSET_RST      7'h04

`endif

// File: logic/bidir_clocked_fifo_mailbox_pkg.sv
// shared types of the two-way queue block
package bidir_clocked_fifo_mailbox_pkg;
   typedef logic [35:0] word_t;
   typedef logic [6:0]  level_t;
   typedef logic [3:0]  flags_t;
   typedef logic [1:0]  offset_sel_t;
endpackage

// File: logic/port_pin_sync.sv
// two-flop synchroniser for one port's clock pin and pins, with clock rise strobe
`timescale 1ns/1ps
module port_pin_sync #(
   parameter int W = 40
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic         clkPin,
   input  wire logic [W-1:0] pins,
   output logic              rise,
   output logic [W-1:0]      pinsS
);
   logic [W:0] s1_r;
   logic [W:0] s2_r;
   logic       clkS3_r;

   // pins travel with the clock so they are aligned when the rise is seen;
   // no reset here: the stages keep tracking the pin, so a release cannot fake a rise
   always_ff @(posedge clk_sys) begin
      s1_r    <= {clkPin, pins};
      s2_r    <= s1_r;
      clkS3_r <= s2_r[W];
   end

   // edge found on the second and third stages only; port clock must be well below clk_sys
   // no strobe while reset is low, so nothing downstream counts a rise seen in reset
   assign rise  = reset_n & s2_r[W] & ~clkS3_r;
   assign pinsS = s2_r[W-1:0];
endmodule

// File: logic/stream_queue.sv
// first-in first-out store with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module stream_queue #(
   parameter int W     = 36,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk_sys,
   input  wire logic                     reset_n,
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [W-1:0]             inData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [W-1:0]                  outData,
   output logic [$clog2(DEPTH):0]        level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW:0]   wPtr_r;
   logic [AW:0]   rPtr_r;
   logic          push;
   logic          pop;

   // pointers carry one extra wrap bit so full and empty differ
   assign level    = wPtr_r - rPtr_r;
   assign inReady  = (level != DEPTH[AW:0]);
   assign outValid = (wPtr_r != rPtr_r);
   assign push     = inValid & inReady;
   assign pop      = outReady & outValid;
   assign outData  = mem[rPtr_r[AW-1:0]];

   // pointer update; order kept by wrapping both pointers the same way
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wPtr_r <= '0;
         rPtr_r <= '0;
      end else begin
         if (push) begin
            wPtr_r <= wPtr_r + 1'b1;
         end
         if (pop) begin
            rPtr_r <= rPtr_r + 1'b1;
         end
      end
   end

   // storage has no reset; unread words are never observed
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wPtr_r[AW-1:0]] <= inData;
      end
   end
endmodule

// File: logic/bidir_clocked_fifo_mailbox.sv
// two queues and two mail registers between port a and port b, one system clock
// What this block does
// - reset may change at any time
// - reset clears pointers and sets flag values
// - full flags rise two port edges after reset
// - reset release latches almost offset from selects
// - data drives only when select and read low
// - qualified port a write enters a to b queue
// - qualified port a read loads output register
// - port b mirrors port a on other queue
// - each queue flag passes two port clocked stages; mail flags are set directly by the mail access
// - each port's flags update on its clock
// - flags follow fill level thresholds with offset
// - read of empty queue ignored, register kept
// - read pointer advances per word delivered
// - new word readable after three read edges
// - late edge after write does not count
// - mail write stores word, flag low, blocks rewrite
// - mail read at far port sets flag high
// - full flag rises second write edge after read
// - almost flags settle after two own edges
`timescale 1ns/1ps
`include "bidir_clocked_fifo_mailbox_regs.svh"
module bidir_clocked_fifo_mailbox #(
   parameter int DEPTH = `QUEUE_DEPTH
) (
   input  wire logic                              clk_sys,
   input  wire logic                              reset_n,
   input  wire logic                              port_a_clock,
   input  wire logic                              port_a_select_n,
   input  wire logic                              port_a_write_not_read,
   input  wire logic                              port_a_enable,
   input  wire logic                              port_a_mail_select,
   input  wire bidir_clocked_fifo_mailbox_pkg::word_t port_a_data_in,
   output bidir_clocked_fifo_mailbox_pkg::word_t  port_a_data_out,
   output logic                                   port_a_data_oe,
   input  wire logic                              port_b_clock,
   input  wire logic                              port_b_select_n,
   input  wire logic                              port_b_write_not_read,
   input  wire logic                              port_b_enable,
   input  wire logic                              port_b_mail_select,
   input  wire bidir_clocked_fifo_mailbox_pkg::word_t port_b_data_in,
   output bidir_clocked_fifo_mailbox_pkg::word_t  port_b_data_out,
   output logic                                   port_b_data_oe,
   input  wire logic                              offset_select_hi,
   input  wire logic                              offset_select_lo,
   output logic                                   port_a_full_n,
   output logic                                   port_a_almost_full_n,
   output logic                                   port_a_empty_n,
   output logic                                   port_a_almost_empty_n,
   output logic                                   port_b_full_n,
   output logic                                   port_b_almost_full_n,
   output logic                                   port_b_empty_n,
   output logic                                   port_b_almost_empty_n,
   output logic                                   a_to_b_mail_flag_n,
   output logic                                   b_to_a_mail_flag_n
);
   localparam int PW = `PIN_CTRL_W + `WORD_W;

   // offset decode, shared by the latch and its check
   function automatic bidir_clocked_fifo_mailbox_pkg::level_t offsetDecode(
      input bidir_clocked_fifo_mailbox_pkg::offset_sel_t sel);
      bidir_clocked_fifo_mailbox_pkg::level_t v;
      unique case (sel)
         2'h3: v = `OFFSET_HH;
         2'h2: v = `OFFSET_HL;
         2'h1: v = `OFFSET_LH;
         2'h0: v = `OFFSET_LL;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and port clock strobes

   logic                                  aRise;
   logic                                  bRise;
   logic [PW-1:0]                         aPinsS;
   logic [PW-1:0]                         bPinsS;
   logic                                  aCsS;
   logic                                  aWnrS;
   logic                                  aEnS;
   logic                                  aMbS;
   logic                                  bCsS;
   logic                                  bWnrS;
   logic                                  bEnS;
   logic                                  bMbS;
   bidir_clocked_fifo_mailbox_pkg::word_t aDataS;
   bidir_clocked_fifo_mailbox_pkg::word_t bDataS;

   port_pin_sync #(.W(PW)) u_sync_a (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .clkPin  (port_a_clock),
      .pins    ({port_a_select_n, port_a_write_not_read, port_a_enable, port_a_mail_select, port_a_data_in}),
      .rise    (aRise),
      .pinsS   (aPinsS)
   );

   port_pin_sync #(.W(PW)) u_sync_b (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .clkPin  (port_b_clock),
      .pins    ({port_b_select_n, port_b_write_not_read, port_b_enable, port_b_mail_select, port_b_data_in}),
      .rise    (bRise),
      .pinsS   (bPinsS)
   );

   // unpack synchronised control and data
   assign {aCsS, aWnrS, aEnS, aMbS, aDataS} = aPinsS;
   assign {bCsS, bWnrS, bEnS, bMbS, bDataS} = bPinsS;

   ////////////////////////////////////////////////////////////////////////////////
   // almost offset latched at reset release

   bidir_clocked_fifo_mailbox_pkg::offset_sel_t selS1_r;
   bidir_clocked_fifo_mailbox_pkg::offset_sel_t selS2_r;
   bidir_clocked_fifo_mailbox_pkg::level_t      offset_r;
   logic                                        resetDone_r;

   // selects are pins, so two flops first; caught in the first cycle after release
   always_ff @(posedge clk_sys) begin
      selS1_r <= {offset_select_hi, offset_select_lo};
      selS2_r <= selS1_r;
   end

   // release may come at any time: it is only sampled on clk_sys
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         resetDone_r <= 1'b0;
         offset_r    <= `OFFSET_RST;
      end else begin
         resetDone_r <= 1'b1;
         if (!resetDone_r) begin
            offset_r <= offsetDecode(selS2_r);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // port decode

   logic aSel;
   logic bSel;
   logic aWrite;
   logic aRead;
   logic aMailWr;
   logic aMailRd;
   logic bWrite;
   logic bRead;
   logic bMailWr;
   logic bMailRd;
   logic abInReady;
   logic baInReady;
   logic abOutValid;
   logic baOutValid;

   // a port acts on a clock rise with select low and enable high
   assign aSel    = aRise & ~aCsS & aEnS;
   assign bSel    = bRise & ~bCsS & bEnS;
   assign aWrite  = aSel & aWnrS & ~aMbS & port_a_full_n & abInReady;
   assign aRead   = aSel & ~aWnrS & ~aMbS & port_a_empty_n & baOutValid;
   assign aMailWr = aSel & aWnrS & aMbS & a_to_b_mail_flag_n;
   assign aMailRd = aSel & ~aWnrS & aMbS;
   assign bWrite  = bSel & bWnrS & ~bMbS & port_b_full_n & baInReady;
   assign bRead   = bSel & ~bWnrS & ~bMbS & port_b_empty_n & abOutValid;
   assign bMailWr = bSel & bWnrS & bMbS & b_to_a_mail_flag_n;
   assign bMailRd = bSel & ~bWnrS & bMbS;

   ////////////////////////////////////////////////////////////////////////////////
   // queues

   bidir_clocked_fifo_mailbox_pkg::word_t  abOutData;
   bidir_clocked_fifo_mailbox_pkg::word_t  baOutData;
   bidir_clocked_fifo_mailbox_pkg::level_t abLevel;
   bidir_clocked_fifo_mailbox_pkg::level_t baLevel;

   stream_queue #(.W(`WORD_W), .DEPTH(DEPTH)) u_a_to_b_queue (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .inValid  (aWrite),
      .inReady  (abInReady),
      .inData   (aDataS),
      .outValid (abOutValid),
      .outReady (bRead),
      .outData  (abOutData),
      .level    (abLevel)
   );

   stream_queue #(.W(`WORD_W), .DEPTH(DEPTH)) u_b_to_a_queue (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .inValid  (bWrite),
      .inReady  (baInReady),
      .inData   (bDataS),
      .outValid (baOutValid),
      .outReady (aRead),
      .outData  (baOutData),
      .level    (baLevel)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // raw flags from fill level, then two stages on each port's own strobe

   bidir_clocked_fifo_mailbox_pkg::level_t highMark;
   bidir_clocked_fifo_mailbox_pkg::flags_t aRaw;
   bidir_clocked_fifo_mailbox_pkg::flags_t bRaw;
   bidir_clocked_fifo_mailbox_pkg::flags_t aFlagS1_r;
   bidir_clocked_fifo_mailbox_pkg::flags_t bFlagS1_r;

   // port a watches the outgoing queue's top and the incoming queue's bottom
   assign highMark = `QUEUE_FULL_LVL - offset_r;
   assign aRaw = {abLevel != `QUEUE_FULL_LVL, abLevel < highMark, baLevel != '0, baLevel > offset_r};
   assign bRaw = {baLevel != `QUEUE_FULL_LVL, baLevel < highMark, abLevel != '0, abLevel > offset_r};

   // level moves the cycle after a transfer, so a rise in that cycle misses it
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         aFlagS1_r <= `FLAG_RST;
         {port_a_full_n, port_a_almost_full_n, port_a_empty_n, port_a_almost_empty_n} <= `FLAG_RST;
      end else if (aRise) begin
         aFlagS1_r <= aRaw;
         {port_a_full_n, port_a_almost_full_n, port_a_empty_n, port_a_almost_empty_n} <= aFlagS1_r;
      end
   end

   // port b flag stages
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         bFlagS1_r <= `FLAG_RST;
         {port_b_full_n, port_b_almost_full_n, port_b_empty_n, port_b_almost_empty_n} <= `FLAG_RST;
      end else if (bRise) begin
         bFlagS1_r <= bRaw;
         {port_b_full_n, port_b_almost_full_n, port_b_empty_n, port_b_almost_empty_n} <= bFlagS1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output registers and mail registers

   bidir_clocked_fifo_mailbox_pkg::word_t aOutReg_r;
   bidir_clocked_fifo_mailbox_pkg::word_t bOutReg_r;
   bidir_clocked_fifo_mailbox_pkg::word_t mailAB_r;
   bidir_clocked_fifo_mailbox_pkg::word_t mailBA_r;

   // output registers change only on a delivered word
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         aOutReg_r <= '0;
         bOutReg_r <= '0;
      end else begin
         if (aRead) begin
            aOutReg_r <= baOutData;
         end
         if (bRead) begin
            bOutReg_r <= abOutData;
         end
      end
   end

   // a mail write and the far read in one cycle: the write wins, flag goes low
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mailAB_r           <= '0;
         mailBA_r           <= '0;
         a_to_b_mail_flag_n <= `MAIL_FLAG_RST;
         b_to_a_mail_flag_n <= `MAIL_FLAG_RST;
      end else begin
         if (aMailWr) begin
            mailAB_r           <= aDataS;
            a_to_b_mail_flag_n <= 1'b0;
         end else if (bMailRd) begin
            a_to_b_mail_flag_n <= 1'b1;
         end
         if (bMailWr) begin
            mailBA_r           <= bDataS;
            b_to_a_mail_flag_n <= 1'b0;
         end else if (aMailRd) begin
            b_to_a_mail_flag_n <= 1'b1;
         end
      end
   end

   // drive and source selection, independent of enable
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         port_a_data_oe  <= 1'b0;
         port_b_data_oe  <= 1'b0;
         port_a_data_out <= '0;
         port_b_data_out <= '0;
      end else begin
         port_a_data_oe  <= ~aCsS & ~aWnrS;
         port_b_data_oe  <= ~bCsS & ~bWnrS;
         port_a_data_out <= aMbS ? mailBA_r : aOutReg_r;
         port_b_data_out <= bMbS ? mailAB_r : bOutReg_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_reset_flags;
      @(posedge clk_sys) !reset_n |=> ({port_a_full_n, port_a_almost_full_n, port_a_empty_n,
         port_a_almost_empty_n} == `FLAG_RST) && a_to_b_mail_flag_n && b_to_a_mail_flag_n;
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("flags wrong after reset");

   property p_full_on_edge;
      @(posedge clk_sys) disable iff (!reset_n) $rose(port_a_full_n) |-> $past(aRise) && $past(aFlagS1_r[`FLAG_FULL]);
   endproperty
   a_full_on_edge: assert property (p_full_on_edge) else $error("full flag rose off a port edge");

   property p_offset_latch;
      @(posedge clk_sys) $rose(reset_n) |=> offset_r == offsetDecode($past(selS2_r));
   endproperty
   a_offset_latch: assert property (p_offset_latch) else $error("offset not latched at release");

   property p_drive;
      @(posedge clk_sys) disable iff (!reset_n) 1'b1 |=> port_a_data_oe == $past(~aCsS & ~aWnrS);
   endproperty
   a_drive: assert property (p_drive) else $error("port a drive enable wrong");

   property p_write_stores;
      @(posedge clk_sys) disable iff (!reset_n) aWrite && !bRead |=> abLevel == $past(abLevel) + 7'h01;
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("write did not add a word");

   property p_read_advances;
      @(posedge clk_sys) disable iff (!reset_n) aRead && !bWrite |=> baLevel == $past(baLevel) - 7'h01;
   endproperty
   a_read_advances: assert property (p_read_advances) else $error("read did not remove a word");

   property p_empty_ignored;
      @(posedge clk_sys) disable iff (!reset_n) aSel && !aWnrS && !aMbS && !port_a_empty_n |=> $stable(aOutReg_r);
   endproperty
   a_empty_ignored: assert property (p_empty_ignored) else $error("read of empty queue changed output");

   property p_no_early_empty;
      @(posedge clk_sys) disable iff (!reset_n) aWrite && abLevel == '0 && !port_b_empty_n |=> !port_b_empty_n [*2];
   endproperty
   a_no_early_empty: assert property (p_no_early_empty) else $error("empty flag rose too soon");

   property p_mail_write;
      @(posedge clk_sys) disable iff (!reset_n) aMailWr |=> !a_to_b_mail_flag_n && mailAB_r == $past(aDataS);
   endproperty
   a_mail_write: assert property (p_mail_write) else $error("mail write not stored");

   property p_mail_read;
      @(posedge clk_sys) disable iff (!reset_n) bMailRd && !aMailWr |=> a_to_b_mail_flag_n && $stable(mailAB_r);
   endproperty
   a_mail_read: assert property (p_mail_read) else $error("mail read did not free flag");

   property p_mail_mux;
      @(posedge clk_sys) disable iff (!reset_n) aMbS |=> port_a_data_out == $past(mailBA_r);
   endproperty
   a_mail_mux: assert property (p_mail_mux) else $error("port a output not from mail");
endmodule

// File: sim/port_master.sv
// behavioural bus master for one port: free running port clock, one operation per rise
`timescale 1ns/1ps
module port_master #(
   parameter int HALF = 40
) (
   output logic                                      portClock,
   output logic                                      selectN,
   output logic                                      writeNotRead,
   output logic                                      enable,
   output logic                                      mailSelect,
   output bidir_clocked_fifo_mailbox_pkg::word_t     drive,
   input  wire bidir_clocked_fifo_mailbox_pkg::word_t bus,
   input  wire logic                                 dataOe
);
   bidir_clocked_fifo_mailbox_pkg::word_t rdData;

   // idle at time zero: deselected, nothing enabled
   initial begin
      portClock = 1'b0;
      selectN = 1'b1;
      writeNotRead = 1'b1;
      enable = 1'b0;
      mailSelect = 1'b0;
      drive = 36'h0;
      rdData = 36'h0;
   end

   // the port clock is continuous, so it runs between operations too
   always #(HALF) portClock = ~portClock;

   ////////////////////////////////////////////////////////////////////////////////
   // controls move at the falling edge, keeping them quiet around the taking rise
   task automatic op(input logic wr, input logic mb, input bidir_clocked_fifo_mailbox_pkg::word_t d);
      @(negedge portClock);
      selectN = 1'b0;
      writeNotRead = wr;
      mailSelect = mb;
      enable = 1'b1;
      drive = wr ? d : ~drive;
      @(posedge portClock);
      @(negedge portClock);
      enable = 1'b0;
      drive = ~drive; // a released bus must not keep showing the old word
      if (!wr) begin
         // the output register settles well inside one port period
         @(posedge portClock);
         rdData = dataOe ? bus : 36'hx;
      end
   endtask

   // deselect the port; its outputs should go quiet
   task automatic idle();
      @(negedge portClock);
      selectN = 1'b1;
   endtask
endmodule

// File: sim/tb_top.sv
// directed testbench: two port masters around the two-way queue and mail block
`timescale 1ns/1ps
module tb_top;
   logic                                  clk_sys = 1'b0;
   logic                                  reset_n = 1'b0;
   logic                                  offHi = 1'b0;
   logic                                  offLo = 1'b0;
   int                                    mismatches = 0;
   int                                    nCompared = 0;
   int                                    offs [4] = '{4, 8, 12, 16};
   logic                                  aClk, aSelN, aWr, aEn, aMb, aOe;
   logic                                  bClk, bSelN, bWr, bEn, bMb, bOe;
   logic [3:0]                            aFlags, bFlags;
   logic [1:0]                            mailFlags;
   bidir_clocked_fifo_mailbox_pkg::word_t aDrive, bDrive, aOut, bOut, aBus, bBus;

   always #5 clk_sys = ~clk_sys;

   // shared data pins: the block wins only while it enables its drivers
   assign aBus = aOe ? aOut : aDrive;
   assign bBus = bOe ? bOut : bDrive;

   bidir_clocked_fifo_mailbox bidir_clocked_fifo_mailbox_inst (
      .clk_sys(clk_sys), .reset_n(reset_n),
      .port_a_clock(aClk), .port_a_select_n(aSelN), .port_a_write_not_read(aWr), .port_a_enable(aEn),
      .port_a_mail_select(aMb), .port_a_data_in(aBus), .port_a_data_out(aOut), .port_a_data_oe(aOe),
      .port_b_clock(bClk), .port_b_select_n(bSelN), .port_b_write_not_read(bWr), .port_b_enable(bEn),
      .port_b_mail_select(bMb), .port_b_data_in(bBus), .port_b_data_out(bOut), .port_b_data_oe(bOe),
      .offset_select_hi(offHi), .offset_select_lo(offLo),
      .port_a_full_n(aFlags[3]), .port_a_almost_full_n(aFlags[2]), .port_a_empty_n(aFlags[1]),
      .port_a_almost_empty_n(aFlags[0]), .port_b_full_n(bFlags[3]), .port_b_almost_full_n(bFlags[2]),
      .port_b_empty_n(bFlags[1]), .port_b_almost_empty_n(bFlags[0]),
      .a_to_b_mail_flag_n(mailFlags[1]), .b_to_a_mail_flag_n(mailFlags[0]));

   // port clocks unrelated to each other and much slower than the system clock
   port_master #(.HALF(40)) masterA (.portClock(aClk), .selectN(aSelN), .writeNotRead(aWr), .enable(aEn),
      .mailSelect(aMb), .drive(aDrive), .bus(aBus), .dataOe(aOe));
   port_master #(.HALF(60)) masterB (.portClock(bClk), .selectN(bSelN), .writeNotRead(bWr), .enable(bEn),
      .mailSelect(bMb), .drive(bDrive), .bus(bBus), .dataOe(bOe));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input bidir_clocked_fifo_mailbox_pkg::word_t seen,
                        input bidir_clocked_fifo_mailbox_pkg::word_t exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic p, input logic mb, input bidir_clocked_fifo_mailbox_pkg::word_t d);
      if (p) masterB.op(1'b1, mb, d);
      else masterA.op(1'b1, mb, d);
   endtask

   task automatic rd(input logic p, input logic mb, input bidir_clocked_fifo_mailbox_pkg::word_t exp);
      if (p) begin
         masterB.op(1'b0, mb, 36'h0);
         check(masterB.rdData, exp);
      end else begin
         masterA.op(1'b0, mb, 36'h0);
         check(masterA.rdData, exp);
      end
   endtask

   // enough rises of both port clocks for every flag to pass its two stages
   task automatic settle();
      repeat (4) @(posedge aClk);
      repeat (4) @(posedge bClk);
   endtask

   // reset spans more than four rises of the slower port clock
   task automatic doReset(input logic [1:0] sel);
      @(negedge clk_sys);
      reset_n = 1'b0;
      {offHi, offLo} = sel;
      repeat (60) @(negedge clk_sys);
      check({32'h0, aFlags}, 36'h4);
      check({32'h0, bFlags}, 36'h4);
      check({34'h0, mailFlags}, 36'h3);
      reset_n = 1'b1;
      @(negedge clk_sys);
      check({35'h0, aFlags[3]}, 36'h0);
      settle();
      check({32'h0, aFlags}, 36'hc);
      check({32'h0, bFlags}, 36'hc);
   endtask

   task automatic conclude();
      if (mismatches == 0 && nCompared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // every offset code, then a full fill and drain, the far direction and both mailboxes
   initial begin
      for (int s = 0; s < 4; s++) begin
         doReset(2'(s));
         for (int i = 0; i <= offs[s]; i++) begin
            if (i == offs[s]) begin
               settle();
               check({32'h0, bFlags}, 36'he);
            end
            wr(1'b0, 1'b0, 36'(i));
         end
         settle();
         check({32'h0, bFlags}, 36'hf);
      end
      for (int i = 17; i < 64; i++) begin
         if (i == 47 || i == 48) begin
            settle();
            check({32'h0, aFlags}, (i == 47) ? 36'hc : 36'h8);
         end
         wr(1'b0, 1'b0, 36'(i));
      end
      settle();
      check({32'h0, aFlags}, 36'h0);
      check({35'h0, aOe}, 36'h0);
      wr(1'b0, 1'b0, 36'h0_0000_0bad);
      for (int i = 0; i < 64; i++) begin
         rd(1'b1, 1'b0, 36'(i));
         if (i == 0) begin
            settle();
            check({32'h0, aFlags}, 36'h8);
         end
      end
      settle();
      check({32'h0, bFlags}, 36'hc);
      rd(1'b1, 1'b0, 36'h3f);
      check({35'h0, bOe}, 36'h1);
      masterB.idle();
      repeat (10) @(negedge clk_sys);
      check({35'h0, bOe}, 36'h0);
      for (int i = 0; i < 3; i++) wr(1'b1, 1'b0, 36'h9_0000_0000 + 36'(i));
      settle();
      for (int i = 0; i < 3; i++) rd(1'b0, 1'b0, 36'h9_0000_0000 + 36'(i));
      settle();
      rd(1'b0, 1'b0, 36'h9_0000_0002);
      for (int p = 0; p < 2; p++) begin
         wr(p[0], 1'b1, 36'ha_5a5a_5a50 + 36'(p));
         settle();
         check({34'h0, mailFlags}, p[0] ? 36'h2 : 36'h1);
         wr(p[0], 1'b1, 36'h0_0000_0bad);
         rd(~p[0], 1'b1, 36'ha_5a5a_5a50 + 36'(p));
         settle();
         check({34'h0, mailFlags}, 36'h3);
         rd(~p[0], 1'b1, 36'ha_5a5a_5a50 + 36'(p));
      end
      conclude();
   end

   // the sequence needs about 60 us; anything far beyond that is a hang
   initial begin
      #300000;
      mismatches++;
      conclude();
   end
endmodule
